/* File: design/pmu_failsafe_pkg.sv */
// Package: register map, field positions, reset values for the failsafe/monitor bank
package pmu_failsafe_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] reset_hold_control_off   = 12'h104;
  localparam logic [11:0] por_pulse_width_off      = 12'h108;
  localparam logic [11:0] ddr_failsafe_control_off = 12'h10c;
  localparam logic [11:0] monitor_osc_control_off  = 12'h180;
  localparam logic [11:0] monitor_window_count_off = 12'h184;
  localparam logic [11:0] monitor_done_status_off  = 12'h190;
  localparam logic [11:0] monitor_freq_result_off  = 12'h194;
  localparam logic [11:0] irq_status_off           = 12'h1a0;
  localparam logic [11:0] irq_mask_off             = 12'h1a4;

  // ----------------------------------------------------------------
  // Valid bits and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] reset_hold_bits   = 16'h1fff;
  localparam logic [15:0] osc_ctrl_bits     = 16'h00ff;
  localparam logic [15:0] reset_hold_rst    = 16'h0000;
  localparam logic [15:0] osc_ctrl_rst      = 16'h0003;
  localparam logic [12:0] por_width_rst     = 13'h0000;
  localparam logic [8:0]  failsafe_rst      = 9'h048;
  localparam logic [8:0]  failsafe_bits     = 9'h17f;
  localparam logic [31:0] window_count_rst  = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int hold_failsafe_bit = 12;
  localparam int lp_req_cfg_bit    = 8;
  localparam int ret_cfg_bit       = 6;
  localparam int ret_request_bit   = 5;
  localparam int clk_gate_en_bit   = 4;
  localparam int sref_en_bit       = 3;
  localparam int io_ret_en_bit     = 2;
  localparam int wdt_trig_en_bit   = 1;
  localparam int therm_trig_en_bit = 0;
  localparam int osc_en_bit        = 1;
  localparam int start_bit         = 0;
  localparam int div_lsb           = 2;
  localparam int div_msb           = 7;

  // Interrupt status/mask layout
  localparam int irq_done_bit      = 0;
  localparam int irq_failure_bit   = 1;
  localparam int irq_width         = 2;

  // ----------------------------------------------------------------
  // Failsafe sequence states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    fs_idle,
    fs_sref,
    fs_hold
  } failsafe_state_t;

endpackage

/* File: design/pmu_failsafe_pvtm_regs.sv */
// Power-management register slice: reset holds, POR pulse, DDR failsafe, ring-oscillator monitor
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module pmu_failsafe_pvtm_regs #(
  parameter int addr_width = 12
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset,
  // Register port
  input  wire logic [addr_width-1:0] addr,
  input  wire logic [31:0]           wdata,
  input  wire logic                  wr_en,
  input  wire logic                  rd_en,
  output logic      [31:0]           rdata,
  // Reset holds and POR pulse
  output logic      [11:0]           soft_reset_hold,
  output logic                       failsafe_reset_hold,
  input  wire logic                  por_trigger,
  output logic                       por_pulse,
  // Failure triggers and DDR handshake (asynchronous pins)
  input  wire logic                  wdt_trigger,
  input  wire logic                  thermal_trigger,
  input  wire logic                  sref_ack,
  // DDR failsafe actions
  output logic                       ddr_lp_request,
  output logic                       ddr_sref_request,
  output logic                       ddr_clk_gate,
  output logic                       ddr_io_retention,
  output logic                       retention_request,
  // Ring-oscillator monitor
  input  wire logic                  ring_osc_in,
  output logic                       ring_osc_enable,
  output logic      [5:0]            clkout_div,
  // Interrupt
  output logic                       irq
);

  if (addr_width < 12) begin
    $error("addr_width must be at least 12");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] masked_write(input logic [15:0] old,
                                               input logic [31:0] wd,
                                               input logic [15:0] valid);
    masked_write = ((old & ~wd[31:16]) | (wd[15:0] & wd[31:16])) & valid;
  endfunction

  function automatic logic hit(input logic [addr_width-1:0] a, input logic [11:0] off);
    hit = (a == addr_width'(off));
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam int irq_w = pmu_failsafe_pkg::irq_width;
  logic [15:0] reset_hold_ff;
  logic [12:0] por_width_ff;
  logic [8:0]  failsafe_ff;
  logic [15:0] osc_ctrl_ff;
  logic [31:0] window_count_ff;
  logic        done_ff;
  logic [31:0] result_ff;
  logic [irq_w-1:0] irq_status_ff;
  logic [irq_w-1:0] irq_mask_ff;
  logic [31:0] rdata_ff;
  logic [12:0] por_cnt_ff;
  logic        por_ff;
  logic [1:0]  wdt_sync_ff;
  logic [1:0]  therm_sync_ff;
  logic [1:0]  ack_sync_ff;
  logic [2:0]  osc_sync_ff;
  logic        measuring_ff;
  logic [31:0] window_left_ff;
  logic [31:0] edge_cnt_ff;
  logic        irq_ff;
  logic        lp_ff;
  logic        sref_ff;
  logic        gate_ff;
  logic        ioret_ff;
  logic        retreq_ff;
  pmu_failsafe_pkg::failsafe_state_t state_ff;
  pmu_failsafe_pkg::failsafe_state_t nxt_state;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire sel_hold   = hit(addr, pmu_failsafe_pkg::reset_hold_control_off);
  wire sel_width  = hit(addr, pmu_failsafe_pkg::por_pulse_width_off);
  wire sel_fs     = hit(addr, pmu_failsafe_pkg::ddr_failsafe_control_off);
  wire sel_osc    = hit(addr, pmu_failsafe_pkg::monitor_osc_control_off);
  wire sel_window = hit(addr, pmu_failsafe_pkg::monitor_window_count_off);
  wire sel_done   = hit(addr, pmu_failsafe_pkg::monitor_done_status_off);
  wire sel_result = hit(addr, pmu_failsafe_pkg::monitor_freq_result_off);
  wire sel_istat  = hit(addr, pmu_failsafe_pkg::irq_status_off);
  wire sel_imask  = hit(addr, pmu_failsafe_pkg::irq_mask_off);

  logic [31:0] rd_mux;
  always_comb begin
    if (sel_hold) begin
      rd_mux = {16'h0000, reset_hold_ff};
    end else if (sel_width) begin
      rd_mux = {19'h00000, por_width_ff};
    end else if (sel_fs) begin
      rd_mux = {23'h000000, failsafe_ff};
    end else if (sel_osc) begin
      rd_mux = {16'h0000, osc_ctrl_ff};
    end else if (sel_window) begin
      rd_mux = window_count_ff;
    end else if (sel_done) begin
      rd_mux = {31'h00000000, done_ff};
    end else if (sel_result) begin
      rd_mux = result_ff;
    end else if (sel_istat) begin
      rd_mux = {30'h00000000, irq_status_ff};
    end else if (sel_imask) begin
      rd_mux = {30'h00000000, irq_mask_ff};
    end else begin
      rd_mux = 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  wire wr_hold  = wr_en && sel_hold;
  wire wr_osc   = wr_en && sel_osc;
  // Start pulse only when the start bit is actually written as one
  wire start_wr = wr_osc && wdata[16 + pmu_failsafe_pkg::start_bit]
                  && wdata[pmu_failsafe_pkg::start_bit];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reset_hold_ff   <= pmu_failsafe_pkg::reset_hold_rst;
      por_width_ff    <= pmu_failsafe_pkg::por_width_rst;
      failsafe_ff     <= pmu_failsafe_pkg::failsafe_rst;
      osc_ctrl_ff     <= pmu_failsafe_pkg::osc_ctrl_rst;
      window_count_ff <= pmu_failsafe_pkg::window_count_rst;
      irq_mask_ff     <= '0;
      rdata_ff        <= 32'h0000_0000;
    end else begin
      if (wr_hold) begin
        reset_hold_ff <= masked_write(reset_hold_ff, wdata,
                                      pmu_failsafe_pkg::reset_hold_bits);
      end
      if (wr_en && sel_width) begin
        por_width_ff <= wdata[12:0];
      end
      if (wr_en && sel_fs) begin
        failsafe_ff <= wdata[8:0] & pmu_failsafe_pkg::failsafe_bits;
      end
      if (wr_osc) begin
        osc_ctrl_ff <= masked_write(osc_ctrl_ff, wdata,
                                    pmu_failsafe_pkg::osc_ctrl_bits);
      end
      if (wr_en && sel_window) begin
        window_count_ff <= wdata;
      end
      if (wr_en && sel_imask) begin
        irq_mask_ff <= wdata[irq_w-1:0];
      end
      rdata_ff <= rd_en ? rd_mux : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Synchronisers (second stage feeds logic and edge detect, never the first)
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wdt_sync_ff   <= 2'h0;
      therm_sync_ff <= 2'h0;
      ack_sync_ff   <= 2'h0;
      osc_sync_ff   <= 3'h0;
    end else begin
      wdt_sync_ff   <= {wdt_sync_ff[0], wdt_trigger};
      therm_sync_ff <= {therm_sync_ff[0], thermal_trigger};
      ack_sync_ff   <= {ack_sync_ff[0], sref_ack};
      osc_sync_ff   <= {osc_sync_ff[1:0], ring_osc_in};
    end
  end

  // ----------------------------------------------------------------
  // POR output pulse
  // ----------------------------------------------------------------
  // A trigger during a running pulse is ignored rather than stretching it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      por_cnt_ff <= 13'h0000;
      por_ff     <= 1'b0;
    end else if (por_trigger && !por_ff) begin
      por_cnt_ff <= por_width_ff;
      por_ff     <= (por_width_ff != 13'h0000);
    end else if (por_cnt_ff > 13'h0001) begin
      por_cnt_ff <= por_cnt_ff - 13'h0001;
    end else begin
      por_cnt_ff <= 13'h0000;
      por_ff     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // DDR failsafe sequence
  // ----------------------------------------------------------------
  wire wdt_fail   = wdt_sync_ff[1] && failsafe_ff[pmu_failsafe_pkg::wdt_trig_en_bit];
  wire therm_fail = therm_sync_ff[1] && failsafe_ff[pmu_failsafe_pkg::therm_trig_en_bit];
  wire failure    = wdt_fail || therm_fail;
  wire sref_en    = failsafe_ff[pmu_failsafe_pkg::sref_en_bit];

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      pmu_failsafe_pkg::fs_idle: begin
        if (failure) begin
          nxt_state = sref_en ? pmu_failsafe_pkg::fs_sref
                              : pmu_failsafe_pkg::fs_hold;
        end
      end
      pmu_failsafe_pkg::fs_sref: begin
        if (ack_sync_ff[1]) begin
          nxt_state = pmu_failsafe_pkg::fs_hold;
        end
      end
      default: begin
        nxt_state = pmu_failsafe_pkg::fs_hold;
      end
    endcase
  end

  // Once entered, the state holds until system reset so memory contents survive; each action follows its current enable bit
  wire in_sref   = (nxt_state == pmu_failsafe_pkg::fs_sref);
  wire in_hold   = (nxt_state == pmu_failsafe_pkg::fs_hold);
  wire active    = in_sref || in_hold;
  wire nxt_lp    = failsafe_ff[pmu_failsafe_pkg::lp_req_cfg_bit] ? active
                   : (in_hold && sref_en);
  wire nxt_sref  = active && sref_en;
  wire nxt_gate  = in_hold && failsafe_ff[pmu_failsafe_pkg::clk_gate_en_bit];
  wire nxt_ioret = in_hold && failsafe_ff[pmu_failsafe_pkg::io_ret_en_bit]
                   && failsafe_ff[pmu_failsafe_pkg::ret_cfg_bit];
  wire nxt_rreq  = active && failsafe_ff[pmu_failsafe_pkg::ret_request_bit];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_ff  <= pmu_failsafe_pkg::fs_idle;
      lp_ff     <= 1'b0;
      sref_ff   <= 1'b0;
      gate_ff   <= 1'b0;
      ioret_ff  <= 1'b0;
      retreq_ff <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      lp_ff     <= nxt_lp;
      sref_ff   <= nxt_sref;
      gate_ff   <= nxt_gate;
      ioret_ff  <= nxt_ioret;
      retreq_ff <= nxt_rreq;
    end
  end

  // ----------------------------------------------------------------
  // Ring-oscillator frequency measurement
  // ----------------------------------------------------------------
  // Oscillator must be well below clk/2 to be counted reliably
  wire osc_on    = osc_ctrl_ff[pmu_failsafe_pkg::osc_en_bit];
  wire osc_edge  = osc_sync_ff[1] && !osc_sync_ff[2];
  wire win_end   = measuring_ff && (window_left_ff <= 32'h0000_0001);
  wire zero_win  = start_wr && osc_on && (window_count_ff == 32'h0000_0000);
  wire meas_done = win_end || zero_win;
  wire done_clr  = wr_en && sel_done && wdata[0];
  wire istat_rd  = rd_en && sel_istat;
  wire [irq_w-1:0] irq_events = {state_ff == pmu_failsafe_pkg::fs_idle && active, meas_done};

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      measuring_ff   <= 1'b0;
      window_left_ff <= 32'h0000_0000;
      edge_cnt_ff    <= 32'h0000_0000;
      result_ff      <= 32'h0000_0000;
      done_ff        <= 1'b0;
    end else begin
      if (start_wr && osc_on && !zero_win) begin
        measuring_ff   <= 1'b1;
        window_left_ff <= window_count_ff;
        edge_cnt_ff    <= 32'h0000_0000;
      end else if (measuring_ff) begin
        window_left_ff <= window_left_ff - 32'h0000_0001;
        edge_cnt_ff    <= edge_cnt_ff + {31'h00000000, osc_edge && osc_on};
        if (win_end || !osc_on) begin
          measuring_ff <= 1'b0;
        end
      end
      if (win_end) begin
        result_ff <= edge_cnt_ff + {31'h00000000, osc_edge && osc_on};
      end else if (zero_win) begin
        result_ff <= 32'h0000_0000;
      end
      // Set wins over a clear in the same cycle
      if (meas_done) begin
        done_ff <= 1'b1;
      end else if (done_clr || start_wr) begin
        done_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status, cleared by reading it
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_status_ff <= '0;
      irq_ff        <= 1'b0;
    end else begin
      irq_status_ff <= irq_events | (istat_rd ? '0 : irq_status_ff);
      irq_ff        <= |((irq_events | (istat_rd ? '0 : irq_status_ff)) & irq_mask_ff);
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata               = rdata_ff;
  assign soft_reset_hold     = reset_hold_ff[11:0];
  assign failsafe_reset_hold = reset_hold_ff[pmu_failsafe_pkg::hold_failsafe_bit];
  assign por_pulse           = por_ff;
  assign ddr_lp_request      = lp_ff;
  assign ddr_sref_request    = sref_ff;
  assign ddr_clk_gate        = gate_ff;
  assign ddr_io_retention    = ioret_ff;
  assign retention_request   = retreq_ff;
  assign ring_osc_enable     = osc_ctrl_ff[pmu_failsafe_pkg::osc_en_bit];
  assign clkout_div          = osc_ctrl_ff[pmu_failsafe_pkg::div_msb:pmu_failsafe_pkg::div_lsb];
  assign irq                 = irq_ff;

endmodule

`default_nettype wire

/* File: test/pmu_failsafe_pvtm_regs_properties.sv */
// Port-level properties of the failsafe and monitor register slice
`timescale 1ns/1ps
`default_nettype none
module pmu_failsafe_pvtm_regs_properties #(
  parameter int addr_width = 12
) (
  input wire logic                  clk,
  input wire logic                  reset,
  input wire logic [addr_width-1:0] addr,
  input wire logic [31:0]           wdata,
  input wire logic                  wr_en,
  input wire logic                  rd_en,
  input wire logic [31:0]           rdata,
  input wire logic [11:0]           soft_reset_hold,
  input wire logic                  failsafe_reset_hold,
  input wire logic                  por_trigger,
  input wire logic                  por_pulse,
  input wire logic                  wdt_trigger,
  input wire logic                  thermal_trigger,
  input wire logic                  sref_ack,
  input wire logic                  ddr_sref_request,
  input wire logic                  ddr_clk_gate,
  input wire logic                  ring_osc_enable,
  input wire logic [5:0]            clkout_div
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  sequence lone_read;
    rd_en ##1 !rd_en;
  endsequence
  sequence hold_write;
    wr_en && addr == 12'h104;
  endsequence
  sequence osc_write;
    wr_en && addr == 12'h180;
  endsequence
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  AST_RDATA_IDLE: assert property (
    rdata != 32'h0 |-> $past(rd_en)) else $error("read data outside read slot");
  AST_RDATA_CLEAR: assert property (
    lone_read |=> rdata == 32'h0) else $error("read data held too long");
  AST_HOLD_MASK: assert property (
    hold_write |=> soft_reset_hold == (($past(wdata[27:16]) & $past(wdata[11:0]))
      | (~$past(wdata[27:16]) & $past(soft_reset_hold)))) else $error("hold mask wrong");
  AST_FS_HOLD: assert property (
    hold_write ##0 wdata[28] |=> failsafe_reset_hold == $past(wdata[12]))
    else $error("failsafe hold wrong");
  AST_OSC_EN: assert property (
    osc_write ##0 wdata[17] |=> ring_osc_enable == $past(wdata[1]))
    else $error("osc enable wrong");
  AST_DIV: assert property (
    osc_write ##0 wdata[23:18] == 6'h3f |=> clkout_div == $past(wdata[7:2]))
    else $error("divider wrong");
  AST_POR_CAUSE: assert property (
    $rose(por_pulse) |-> $past(por_trigger)) else $error("pulse without trigger");
  AST_SREF_CAUSE: assert property (
    $rose(ddr_sref_request) |-> $past(wdt_trigger, 2) || $past(thermal_trigger, 2))
    else $error("self-refresh without trigger");
  AST_GATE_AFTER_ACK: assert property (
    $rose(ddr_clk_gate) && ddr_sref_request |-> $past(sref_ack, 2))
    else $error("clock gated before self-refresh");
endmodule
bind pmu_failsafe_pvtm_regs pmu_failsafe_pvtm_regs_properties #(.addr_width(addr_width)) chk_u (
  .clk, .reset, .addr, .wdata, .wr_en, .rd_en, .rdata, .soft_reset_hold, .failsafe_reset_hold,
  .por_trigger, .por_pulse, .wdt_trigger, .thermal_trigger, .sref_ack, .ddr_sref_request,
  .ddr_clk_gate, .ring_osc_enable, .clkout_div);
`default_nettype wire

/* File: test/pmu_failsafe_pvtm_regs_test.sv */
// Self-checking bench for the failsafe and monitor register slice
`timescale 1ns/1ps
`default_nettype none
module pmu_failsafe_pvtm_regs_test;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clk, reset, wr_en, rd_en, por_trigger, wdt_trigger, thermal_trigger, sref_ack;
  logic        ring_osc_in, failsafe_reset_hold, por_pulse, ddr_lp_request, ddr_sref_request;
  logic        ddr_clk_gate, ddr_io_retention, retention_request, ring_osc_enable, irq;
  logic [11:0] addr, soft_reset_hold;
  logic [31:0] wdata, rdata, seed, got, exp, d, m;
  logic [5:0]  clkout_div;
  logic [1:0]  osc_cnt;
  int          bad_count, total_checks, cycles, n, r, k;
  logic [11:0] ra[8] = '{12'h104, 12'h108, 12'h10c, 12'h180, 12'h184, 12'h190, 12'h194, 12'h1f0};
  logic [31:0] rv[8] = '{32'h0, 32'h0, 32'h48, 32'h3, 32'h0, 32'h0, 32'h0, 32'h0};
  logic [11:0] pa[3] = '{12'h108, 12'h184, 12'h10c};
  logic [31:0] pm[3] = '{32'h1fff, 32'hffff_ffff, 32'h17f};
  logic [31:0] pw[3] = '{32'h0, 32'h1, 32'h7};

  pmu_failsafe_pvtm_regs dut_u (
    .clk, .reset, .addr, .wdata, .wr_en, .rd_en, .rdata, .soft_reset_hold, .failsafe_reset_hold,
    .por_trigger, .por_pulse, .wdt_trigger, .thermal_trigger, .sref_ack, .ddr_lp_request,
    .ddr_sref_request, .ddr_clk_gate, .ddr_io_retention, .retention_request, .ring_osc_in,
    .ring_osc_enable, .clkout_div, .irq);

  // ----------------------------------------------------------------
  // Clock, ring oscillator, timeout
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Oscillator stands still while disabled, one rising edge per four clocks
  always @(posedge clk) begin
    if (ring_osc_enable === 1'b1) begin
      osc_cnt <= osc_cnt + 2'd1;
      ring_osc_in <= osc_cnt[1];
    end
    cycles = cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 got = rdata;
  endtask
  task automatic wait_clk(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    reset = 1'b1;
    {wr_en, rd_en, por_trigger, wdt_trigger, thermal_trigger, sref_ack, ring_osc_in} = '0;
    addr = '0;
    wdata = '0;
    osc_cnt = '0;
    seed = 32'hce53d31d;
    {bad_count, total_checks, cycles} = '0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    for (n = 0; n < 8; n++) begin
      rd(ra[n]);
      check("reset value", got, rv[n]);
    end
    $display("test reset values done");
    // Masked pair: reset holds, then oscillator control
    for (r = 0; r < 2; r++) begin
      exp = r ? 32'h3 : 32'h0;
      for (n = 0; n < 8; n++) begin
        d = rnd();
        m = {16'h0, d[31:16] & (r ? 16'h00ff : 16'h1fff)};
        exp = (exp & ~m) | (d & m);
        wr(r ? 12'h180 : 12'h104, d);
        #1 got = r ? 32'({clkout_div, ring_osc_enable}) : 32'({failsafe_reset_hold, soft_reset_hold});
        check("masked outputs", got, r ? exp >> 1 : exp);
        rd(r ? 12'h180 : 12'h104);
        check("masked reg", got, exp);
      end
    end
    for (n = 0; n < 3; n++) begin
      d = rnd();
      wr(pa[n], d);
      rd(pa[n]);
      check("plain reg", got, d & pm[n]);
    end
    wr(12'h104, 32'h1fff_0000);
    wr(12'h180, 32'h00ff_0002);
    wr(12'h10c, 32'h48);
    $display("test register access done");
    for (n = 0; n < 3; n++) begin
      wr(12'h108, pw[n]);
      @(posedge clk) por_trigger <= 1'b1;
      @(posedge clk) por_trigger <= 1'b0;
      k = 0;
      repeat (12) begin
        #1;
        if (por_pulse === 1'b1) k++;
        @(posedge clk);
      end
      check("por width", 32'(k), pw[n]);
    end
    $display("test por pulse done");
    // Drop events left behind by the random start writes
    rd(12'h1a0);
    wr(12'h1a4, 32'h1);
    wr(12'h184, 32'd20);
    wr(12'h180, 32'h0001_0001);
    k = 0;
    while (irq !== 1'b1 && k < 40) begin
      wait_clk(1);
      k++;
    end
    check("done irq", 32'(irq), 32'h1);
    rd(12'h190);
    check("done flag", got, 32'h1);
    rd(12'h194);
    check("edge count", got, 32'd5);
    rd(12'h1a0);
    check("irq status", got, 32'h1);
    wait_clk(2);
    check("irq cleared", 32'(irq), 32'h0);
    wr(12'h180, 32'h0002_0000);
    wr(12'h190, 32'h1);
    wr(12'h180, 32'h0001_0001);
    wait_clk(30);
    rd(12'h190);
    check("start while stopped", got, 32'h0);
    wr(12'h180, 32'h0002_0002);
    $display("test monitor done");
    wr(12'h10c, 32'h7e);
    @(posedge clk) thermal_trigger <= 1'b1;
    wait_clk(8);
    check("thermal disabled", 32'(ddr_sref_request), 32'h0);
    @(posedge clk) wdt_trigger <= 1'b1;
    wait_clk(6);
    got = 32'({ddr_sref_request, ddr_lp_request, ddr_clk_gate, ddr_io_retention, retention_request});
    check("sref phase", got, 32'h11);
    @(posedge clk) sref_ack <= 1'b1;
    wait_clk(6);
    got = 32'({ddr_sref_request, ddr_lp_request, ddr_clk_gate, ddr_io_retention, retention_request});
    check("hold phase", got, 32'h1f);
    check("failure masked", 32'(irq), 32'h0);
    wr(12'h1a4, 32'h3);
    wait_clk(2);
    check("failure irq", 32'(irq), 32'h1);
    rd(12'h1a0);
    check("failure status", got, 32'h2);
    wr(12'h10c, 32'h3e);
    wait_clk(1);
    check("retention off", 32'(ddr_io_retention), 32'h0);
    $display("test watchdog failure done");
    @(posedge clk) {wdt_trigger, thermal_trigger, sref_ack} <= 3'b000;
    reset <= 1'b1;
    wait_clk(10);
    check("outputs in reset", 32'({ddr_sref_request, ddr_clk_gate, irq}), 32'h0);
    @(posedge clk) reset <= 1'b0;
    wr(12'h10c, 32'h109);
    @(posedge clk) thermal_trigger <= 1'b1;
    wait_clk(6);
    check("early low power", 32'({ddr_sref_request, ddr_lp_request}), 32'h3);
    $display("test thermal failure done");
    conclude();
  end
endmodule
`default_nettype wire
